// [rtl/eesq_eraser.sv]
`timescale 1ns/1ps
module eesq_eraser (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Launch request.
  input wire logic start,
  input wire logic [7:0] base,
  input wire logic [8:0] words,
  // Progress.
  output logic busy_q,
  output logic done_q,
  // Array erase port.
  output logic ee_erase_q,
  output logic [7:0] ee_addr_q
);
  eesq_pkg::eesq_eng_t st_q, st_d;
  logic [12:0] cyc_q, cyc_d;
  logic [8:0] left_q, left_d;
  logic busy_d, done_d, erase_d;
  logic [7:0] addr_d;

  // Each word gets a full erase pulse, then the address steps on.
  always_comb
  begin
    st_d = st_q;
    cyc_d = cyc_q;
    left_d = left_q;
    busy_d = busy_q;
    done_d = 1'b0;
    erase_d = ee_erase_q;
    addr_d = ee_addr_q;
    case (st_q)
      eesq_pkg::ENG_IDLE:
      begin
        if (start)
        begin
          st_d = eesq_pkg::ENG_PULSE; // R7
          cyc_d = eesq_pkg::ERASE_CYC_M1;
          left_d = words;
          addr_d = base;
          busy_d = 1'b1;
          erase_d = 1'b1;
        end
      end
      eesq_pkg::ENG_PULSE:
      begin
        if (cyc_q != 13'h0000)
          cyc_d = cyc_q - 13'h0001;
        else if (left_q == 9'h001)
        begin
          st_d = eesq_pkg::ENG_IDLE;
          busy_d = 1'b0;
          erase_d = 1'b0;
          done_d = 1'b1; // R8
        end
        else
        begin
          cyc_d = eesq_pkg::ERASE_CYC_M1;
          left_d = left_q - 9'h001; // R1
          addr_d = ee_addr_q + 8'h01;
        end
      end
      default: st_d = eesq_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= eesq_pkg::ENG_IDLE;
      cyc_q <= 13'h0000;
      left_q <= 9'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ee_erase_q <= 1'b0;
      ee_addr_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      left_q <= left_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ee_erase_q <= erase_d;
      ee_addr_q <= addr_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_erase: assert property (busy_q |-> ee_erase_q) // R7
    else $error("Erase pulse missing while busy.");
  a_done_ends: assert property (done_q |-> !busy_q && !ee_erase_q && $past(busy_q)) // R8
    else $error("Done without a finished erase.");
  a_addr_step: assert property (ee_erase_q && $past(ee_erase_q) && ee_addr_q != $past(ee_addr_q)
    |-> ee_addr_q == $past(ee_addr_q) + 8'h01) // R1
    else $error("Erase address skipped a word.");
  a_done_pulse: assert property (done_q |=> !done_q) // R8
    else $error("Done lasted more than one cycle.");
  c_multi_word: cover property (ee_erase_q && $past(ee_erase_q) && ee_addr_q != $past(ee_addr_q));
endmodule

// [rtl/eesq_pkg.sv]
// Overview of operation
// (R1) Erase the whole array, or one, four or eight words per operation.
// (R2) Control bits 1:0 select how many words an erase covers.
// (R3) Software programs the erase size before starting a partial erase.
// (R4) Software loads the target address into page and working registers first.
// (R5) Software may clear the done flag and unmask its interrupt beforehand.
// (R6) Software writes the unlock keys immediately before setting the start bit.
// (R7) Start after a valid unlock launches the erase with the configured size.
// (R8) Start bit reads high during erase; completion sets the done flag.
// (R9) Single-word erase uses control value 0x4058 before the unlock sequence.
// (R10) Software blocks interrupts so key and start writes stay back to back.
// (R11) A start write without the complete unlock just before is ignored.
package eesq_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PAGE = 8'h04;
  localparam logic [7:0] OFS_WORK = 8'h08;
  localparam logic [7:0] OFS_KEY = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam int CTRL_START = 15;
  localparam int CTRL_WREN = 14;
  localparam int CTRL_ERASE = 6;
  localparam logic [14:0] CTRL_RST = 15'h0000;
  localparam logic [1:0] SIZE_ONE = 2'h0;
  localparam logic [1:0] SIZE_FOUR = 2'h1;
  localparam logic [1:0] SIZE_EIGHT = 2'h2;
  localparam logic [1:0] SIZE_ALL = 2'h3;
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00aa;
  localparam int STAT_DONE = 0;
  localparam int STAT_REFUSED = 1;
  localparam int ADDR_W = 8;
  localparam int CLK_MHZ = 20;
  localparam int ERASE_WORD_NS = 4000;
  localparam int ERASE_CYC = (ERASE_WORD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [12:0] ERASE_CYC_M1 = 13'(ERASE_CYC - 1);
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} eesq_key_t;
  typedef enum logic {ENG_IDLE, ENG_PULSE} eesq_eng_t;
endpackage

// [rtl/eesq_top.sv]
`timescale 1ns/1ps
module eesq_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Interrupt.
  output logic irq_q,
  // Array erase port.
  output logic ee_erase_q,
  output logic [7:0] ee_addr_q,
  output logic [7:0] ee_page_q
);
  logic [14:0] ctrl_q, ctrl_d;
  logic [7:0] page_q, page_d;
  logic [15:0] work_q, work_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  eesq_pkg::eesq_key_t key_q, key_d;
  logic launch_q, launch_d;
  logic [7:0] base_q, base_d;
  logic [8:0] words_q, words_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, irq_d;
  logic eng_busy, eng_done;
  logic acc, done_wr, mapped;
  logic [7:0] ofs;
  logic [1:0] size;
  logic [7:0] align;
  logic wr_ctrl, start_req, armed_ok;

  assign ofs = paddr[7:0];
  assign acc = psel && penable && !pready_q;
  assign done_wr = psel && penable && pready_q;
  assign mapped = (paddr[31:8] == 24'h000000) && (ofs == eesq_pkg::OFS_CTRL
    || ofs == eesq_pkg::OFS_PAGE || ofs == eesq_pkg::OFS_WORK || ofs == eesq_pkg::OFS_KEY
    || ofs == eesq_pkg::OFS_STAT || ofs == eesq_pkg::OFS_MASK);
  assign wr_ctrl = done_wr && pwrite && mapped && ofs == eesq_pkg::OFS_CTRL;
  assign start_req = wr_ctrl && pwdata[eesq_pkg::CTRL_START];
  assign size = pwdata[1:0];
  assign armed_ok = key_q == eesq_pkg::KEY_ARMED && !eng_busy && !launch_q
    && pwdata[eesq_pkg::CTRL_WREN] && pwdata[eesq_pkg::CTRL_ERASE];

  // Base address is aligned down to the block that the size selects.
  always_comb
  begin
    case (size)
      eesq_pkg::SIZE_FOUR: align = 8'hfc;
      eesq_pkg::SIZE_EIGHT: align = 8'hf8;
      eesq_pkg::SIZE_ALL: align = 8'h00;
      default: align = 8'hff;
    endcase
  end

  // Register file, unlock tracking and launch.
  always_comb
  begin
    ctrl_d = ctrl_q;
    page_d = page_q;
    work_d = work_q;
    mask_d = mask_q;
    stat_d = stat_q;
    key_d = key_q;
    launch_d = 1'b0;
    base_d = base_q;
    words_d = words_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (acc)
    begin
      pready_d = 1'b1;
      pslverr_d = !mapped;
      prdata_d = 32'h00000000;
      case (ofs)
        eesq_pkg::OFS_CTRL: prdata_d = {16'h0000, eng_busy | launch_q, ctrl_q}; // R8
        eesq_pkg::OFS_PAGE: prdata_d = {24'h000000, page_q};
        eesq_pkg::OFS_WORK: prdata_d = {16'h0000, work_q};
        eesq_pkg::OFS_STAT: prdata_d = {30'h00000000, stat_q};
        eesq_pkg::OFS_MASK: prdata_d = {30'h00000000, mask_q};
        default: prdata_d = 32'h00000000;
      endcase
      if (!mapped)
        prdata_d = 32'h00000000;
    end
    if (done_wr && !pwrite && mapped && ofs == eesq_pkg::OFS_STAT)
      stat_d = 2'h0;
    if (done_wr && pwrite && mapped)
    begin
      key_d = eesq_pkg::KEY_IDLE; // R11
      case (ofs)
        eesq_pkg::OFS_CTRL: ctrl_d = pwdata[14:0]; // R2
        eesq_pkg::OFS_PAGE: page_d = pwdata[7:0];
        eesq_pkg::OFS_WORK: work_d = pwdata[15:0];
        eesq_pkg::OFS_MASK: mask_d = pwdata[1:0];
        eesq_pkg::OFS_KEY:
        begin
          if (pwdata[15:0] == eesq_pkg::KEY_FIRST)
            key_d = eesq_pkg::KEY_HALF;
          else if (pwdata[15:0] == eesq_pkg::KEY_SECOND && key_q == eesq_pkg::KEY_HALF)
            key_d = eesq_pkg::KEY_ARMED;
        end
        default: key_d = eesq_pkg::KEY_IDLE;
      endcase
    end
    if (start_req && armed_ok)
    begin
      launch_d = 1'b1; // R7
      base_d = work_q[7:0] & align;
      case (size)
        eesq_pkg::SIZE_FOUR: words_d = 9'h004;
        eesq_pkg::SIZE_EIGHT: words_d = 9'h008;
        eesq_pkg::SIZE_ALL: words_d = 9'h100;
        default: words_d = 9'h001;
      endcase
    end
    if (start_req && !armed_ok)
      stat_d[eesq_pkg::STAT_REFUSED] = 1'b1; // R11
    if (eng_done)
      stat_d[eesq_pkg::STAT_DONE] = 1'b1; // R8
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= eesq_pkg::CTRL_RST;
      page_q <= 8'h00;
      work_q <= 16'h0000;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      key_q <= eesq_pkg::KEY_IDLE;
      launch_q <= 1'b0;
      base_q <= 8'h00;
      words_q <= 9'h000;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      ee_page_q <= 8'h00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      page_q <= page_d;
      work_q <= work_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      key_q <= key_d;
      launch_q <= launch_d;
      base_q <= base_d;
      words_q <= words_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      ee_page_q <= launch_d ? page_q : ee_page_q;
    end
  end

  eesq_eraser u_eraser (
    .pclk(pclk),
    .presetn(presetn),
    .start(launch_q),
    .base(base_q),
    .words(words_q),
    .busy_q(eng_busy),
    .done_q(eng_done),
    .ee_erase_q(ee_erase_q),
    .ee_addr_q(ee_addr_q)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_launch_busy: assert property (launch_q |=> eng_busy && ee_addr_q == $past(base_q)) // R7
    else $error("Launch did not start the eraser.");
  a_refuse_start: assert property (start_req && key_q != eesq_pkg::KEY_ARMED
    |=> !launch_q && stat_q[eesq_pkg::STAT_REFUSED]) // R11
    else $error("Start accepted without unlock.");
  a_done_flag: assert property (eng_done |=> stat_q[eesq_pkg::STAT_DONE]) // R8
    else $error("Completion flag not set.");
  a_size_words: assert property (start_req && armed_ok && size == eesq_pkg::SIZE_FOUR
    |=> words_q == 9'h004 && base_q[1:0] == 2'h0) // R2
    else $error("Four-word erase misconfigured.");
  a_irq_level: assert property ((stat_q[0] && mask_q[0]) [*2] |-> irq_q) // R8
    else $error("Interrupt not raised.");
  c_erase_done: cover property (launch_q ##[1:1000] eng_done);
  c_refused: cover property (start_req && !armed_ok);
  c_erase_all: cover property (launch_q && words_q == 9'h100);
endmodule

// [verification/tb_eesq_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_eesq_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q, ee_erase_q;
  logic [7:0] ee_addr_q, ee_page_q;
  int mismatches = 0;
  int n_checks = 0;
  int n_words = 0;
  logic [7:0] first_addr = 8'h00;
  logic [7:0] last_addr = 8'h00;
  logic last_erase = 1'b0;
  logic [31:0] rd;
  logic err;
  always #25 pclk = ~pclk;
  eesq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .irq_q(irq_q), .ee_erase_q(ee_erase_q),
    .ee_addr_q(ee_addr_q), .ee_page_q(ee_page_q));
  // Counts each distinct word placed on the erase port.
  always @(posedge pclk)
  begin
    if (ee_erase_q === 1'b1 && (last_erase !== 1'b1 || ee_addr_q !== last_addr))
    begin
      if (n_words == 0) first_addr = ee_addr_q;
      n_words++;
    end
    last_erase = ee_erase_q;
    last_addr = ee_addr_q;
  end
  task results();
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready_q)
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function logic [7:0] exp_base(logic [1:0] s, logic [7:0] w);
    case (s)
      2'h1: return w & 8'hfc;
      2'h2: return w & 8'hf8;
      2'h3: return 8'h00;
      default: return w;
    endcase
  endfunction
  function int exp_words(logic [1:0] s);
    return (s == 2'h0) ? 1 : (s == 2'h1) ? 4 : (s == 2'h2) ? 8 : 256;
  endfunction
  initial
  begin
    repeat (80000) @(posedge pclk);
    mismatches++;
    results();
  end
  initial
  begin
    logic [1:0] s;
    logic [7:0] pg, wk;
    logic [15:0] ctrl;
    int k, n;
    void'($urandom(5));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, eesq_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, eesq_pkg::OFS_MASK, 32'h2);
    // Start without keys, with a wrong key, and with a write between keys and start.
    for (k = 0; k < 3; k++)
    begin
      apb(1'b1, eesq_pkg::OFS_CTRL, 32'h4058);
      if (k > 0) apb(1'b1, eesq_pkg::OFS_KEY, {16'h0, eesq_pkg::KEY_FIRST});
      if (k == 1) apb(1'b1, eesq_pkg::OFS_KEY, 32'h12);
      if (k == 2) apb(1'b1, eesq_pkg::OFS_KEY, {16'h0, eesq_pkg::KEY_SECOND});
      if (k == 2) apb(1'b1, eesq_pkg::OFS_PAGE, 32'h11);
      apb(1'b1, eesq_pkg::OFS_CTRL, 32'hc058);
      repeat (4) @(posedge pclk);
      `CHK("irq refused", 1'b1, irq_q)
      apb(1'b0, eesq_pkg::OFS_STAT, 32'h0);
      `CHK("stat refused", 32'h2, rd)
    end
    `CHK("no erase", 0, n_words)
    // Every size once, then random sizes and addresses.
    for (k = 0; k < 6; k++)
    begin
      s = (k < 4) ? 2'(k) : 2'($urandom_range(0, 2));
      pg = 8'($urandom);
      wk = 8'($urandom);
      ctrl = 16'h4058 | {14'h0, s};
      apb(1'b1, eesq_pkg::OFS_MASK, {31'h0, k != 1});
      apb(1'b1, eesq_pkg::OFS_CTRL, {16'h0, ctrl});
      apb(1'b1, eesq_pkg::OFS_PAGE, {24'h0, pg});
      apb(1'b1, eesq_pkg::OFS_WORK, {16'h0, 8'($urandom), wk});
      apb(1'b0, eesq_pkg::OFS_STAT, 32'h0);
      n_words = 0;
      apb(1'b1, eesq_pkg::OFS_KEY, {16'h0, eesq_pkg::KEY_FIRST});
      apb(1'b1, eesq_pkg::OFS_KEY, {16'h0, eesq_pkg::KEY_SECOND});
      apb(1'b1, eesq_pkg::OFS_CTRL, {16'h0, ctrl | 16'h8000});
      apb(1'b0, eesq_pkg::OFS_CTRL, 32'h0);
      `CHK("busy", 1'b1, rd[15])
      `CHK("ctrl back", ctrl[14:0], rd[14:0])
      `CHK("irq early", 1'b0, irq_q)
      n = 0;
      while (rd[15] === 1'b1 && n < 12000)
      begin
        apb(1'b0, eesq_pkg::OFS_CTRL, 32'h0);
        n++;
      end
      repeat (3) @(posedge pclk);
      `CHK("words", exp_words(s), n_words)
      `CHK("base", exp_base(s, wk), first_addr)
      `CHK("page", pg, ee_page_q)
      `CHK("erase off", 1'b0, ee_erase_q)
      `CHK("irq", (k != 1), irq_q)
      apb(1'b0, eesq_pkg::OFS_STAT, 32'h0);
      `CHK("done", 32'h1, rd)
      repeat (3) @(posedge pclk);
      `CHK("irq clear", 1'b0, irq_q)
    end
    results();
  end
endmodule
